// ---- hdl/amd_pkg.sv ----
// Purpose: shared constants and types for the accumulator multiply / dot-product unit
// Assumes: 64-bit operands, four 128-bit accumulators, 32-bit classic Wishbone register port
// Notes:   every offset, field position, reset value and opcode lives here once
package amd_pkg;

    // ****************************************************************
    // instruction word fields
    // ****************************************************************
    localparam int          MAJOR_LSB    = 26;
    localparam int          ACSEL_LSB    = 11;
    localparam int          MINOR_LSB    = 6;
    localparam int          FUNC_LSB     = 0;
    localparam logic [5:0]  EXTENSION_MAJOR_OPCODE = 6'h1f;
    localparam logic [5:0]  FN_WORD_QUAD = 6'h34;   // function group 110100
    localparam logic [5:0]  FN_PAIR      = 6'h30;   // function group 110000
    localparam logic [5:0]  FN_EXTRACT   = 6'h3c;   // function group 111100
    localparam logic [4:0]  MN_MSUB      = 5'h1b;
    localparam logic [4:0]  MN_MSUBU     = 5'h1f;
    localparam logic [4:0]  MN_SHIFT_IN  = 5'h1f;
    localparam logic [4:0]  MN_INT_DOT   = 5'h00;
    localparam logic [4:0]  MN_FRAC_DOT  = 5'h04;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0]  OFS_CTRL     = 8'h00;   // signal_processing_control_reg
    localparam logic [7:0]  OFS_ENABLE   = 8'h04;   // bit 0 enables the extension
    localparam logic [7:0]  OFS_STATUS   = 8'h08;   // sticky events, write one to clear
    localparam logic [7:0]  OFS_MASK     = 8'h0c;   // interrupt mask, same layout
    localparam logic [7:0]  OFS_ACC_BASE = 8'h40;   // 4 accumulators x 4 words
    localparam logic [7:0]  OFS_ACC_END  = 8'h80;

    // ****************************************************************
    // control register fields and reset values
    // ****************************************************************
    localparam int          POS_LSB      = 0;
    localparam int          POS_W        = 7;
    localparam logic [6:0]  POS_STEP     = 7'h40;   // shift-in advances by 64
    localparam logic [6:0]  POS_LIMIT    = 7'h40;   // above this the new value is undefined
    localparam int          OUFLAG_LSB   = 16;
    localparam int          OUFLAG_W     = 8;
    localparam int          SATFLAG_LSB  = 16;      // plus accumulator index
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
    localparam int          ENABLE_BIT   = 0;

    // ****************************************************************
    // interrupt events
    // ****************************************************************
    localparam int          EV_W         = 3;
    localparam int          EV_SAT       = 0;
    localparam int          EV_RESERVED  = 1;
    localparam int          EV_DISABLED  = 2;
    localparam logic [2:0]  EV_RESET     = 3'h0;

    // ****************************************************************
    // fractional arithmetic
    // ****************************************************************
    localparam logic [15:0] Q15_MINUS_ONE = 16'h8000;
    localparam logic [31:0] Q31_MAX       = 32'h7fff_ffff;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_MSUB,
        OP_MSUBU,
        OP_SHIFT_IN,
        OP_DOT_PAIR,
        OP_DOT_QUAD,
        OP_DOT_FRAC
    } amd_op_t;

    // decoded instruction plus operand values from the pipeline
    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [63:0] source_operand_a;
        logic [63:0] source_operand_b;
    } amd_issue_t;

    // per-instruction answer to the pipeline
    typedef struct packed {
        logic       done;
        logic       exc_reserved;
        logic       exc_disabled;
        logic [1:0] accumulator_select;
    } amd_result_t;

endpackage

// ---- hdl/amd_mult.sv ----
// Purpose: one signed-or-unsigned multiplier lane
// Assumes: combinational, result used in the same cycle
// Notes:   extends by one bit so one signed multiply covers both kinds
`timescale 1ns/10ps
`default_nettype none

module amd_mult #(
    parameter int W = 16
) (
    input  wire logic [W-1:0]   a,          // multiplicand
    input  wire logic [W-1:0]   b,          // multiplier
    input  wire logic           is_signed,  // 1: two's complement operands
    output logic      [2*W-1:0] prod        // full product
);
    logic signed [W:0]     ax;
    logic signed [W:0]     bx;
    logic signed [2*W+1:0] full;

    // sign or zero extension picks the interpretation
    assign ax   = $signed({is_signed & a[W-1], a});
    assign bx   = $signed({is_signed & b[W-1], b});
    assign full = ax * bx;
    assign prod = full[2*W-1:0];   // top bits are pure extension
endmodule // amd_mult

`default_nettype wire

// ---- hdl/amd_unit.sv ----
// Purpose: accumulator multiply-subtract, shift-in and dot-product datapath
// Assumes: one instruction per cycle from the pipeline, result visible next cycle
// Notes:   registers and accumulators reachable over classic Wishbone
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - signed word products subtracted from accumulator
// - unsigned word products subtracted from accumulator
// - two-bit index picks accumulator, zero is legacy
// - accumulators not picked by the index keep values
// - shift-in moves low to high, loads source
// - shift-in adds 64 to position field
// - position above 64 gives undefined new position
// - pair dot product adds into 64-bit accumulator
// - pair result halves sign-extended to 64 bits
// - quad dot product 34-bit sum into 128 bits
// - integer dot products never touch overflow flags
// - fractional products shifted left one to Q31
// - minus one squared saturates to Q31 maximum
// - fractional products accumulate into 64-bit accumulator
// - only reserved and disabled exceptions raised
// - saturation sets flag bit 16 plus index
module amd_unit (
    input  wire logic                  clk,        // 200 MHz core clock
    input  wire logic                  resetn,     // async reset, active low
    input  wire logic                  wb_cyc_i,   // bus cycle
    input  wire logic                  wb_stb_i,   // strobe
    input  wire logic                  wb_we_i,    // write enable
    input  wire logic [7:0]            wb_adr_i,   // byte address
    input  wire logic [3:0]            wb_sel_i,   // byte lanes
    input  wire logic [31:0]           wb_dat_i,   // write data
    output logic      [31:0]           wb_dat_o,   // read data
    output logic                       wb_ack_o,   // acknowledge
    input  wire amd_pkg::amd_issue_t   issue_req,  // instruction from pipeline
    output amd_pkg::amd_result_t       issue_rsp,  // completion / exception
    output logic                       irq         // level interrupt
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic [3:0][127:0]       acc_q;
    logic [3:0][127:0]       next_acc_arr;
    logic [31:0]             ctrl_q;
    logic [31:0]             next_ctrl;
    logic [31:0]             enable_q;
    logic [amd_pkg::EV_W-1:0] status_q;
    logic [amd_pkg::EV_W-1:0] next_status;
    logic [amd_pkg::EV_W-1:0] mask_q;
    logic [amd_pkg::EV_W-1:0] next_mask;

    // ****************************************************************
    // instruction decode
    // ****************************************************************
    logic [31:0]             instr;
    logic [63:0]             opa;
    logic [63:0]             opb;
    logic [5:0]              major;
    logic [4:0]              minor;
    logic [5:0]              func;
    logic [1:0]              idx;
    amd_pkg::amd_op_t        op;
    logic                    known;
    logic                    enabled;
    logic                    exec;
    logic                    refuse_resv;
    logic                    refuse_dis;

    assign instr   = issue_req.instr;
    assign opa     = issue_req.source_operand_a;
    assign opb     = issue_req.source_operand_b;
    assign major   = instr[amd_pkg::MAJOR_LSB +: 6];
    assign minor   = instr[amd_pkg::MINOR_LSB +: 5];
    assign func    = instr[amd_pkg::FUNC_LSB +: 6];
    assign idx     = instr[amd_pkg::ACSEL_LSB +: 2];

    // opcode match on major, minor and function group
    assign op =
        (major != amd_pkg::EXTENSION_MAJOR_OPCODE) ? amd_pkg::OP_NONE :
        (func == amd_pkg::FN_WORD_QUAD && minor == amd_pkg::MN_MSUB) ? amd_pkg::OP_MSUB :
        (func == amd_pkg::FN_WORD_QUAD && minor == amd_pkg::MN_MSUBU) ? amd_pkg::OP_MSUBU :
        (func == amd_pkg::FN_EXTRACT && minor == amd_pkg::MN_SHIFT_IN) ? amd_pkg::OP_SHIFT_IN :
        (func == amd_pkg::FN_PAIR && minor == amd_pkg::MN_INT_DOT) ? amd_pkg::OP_DOT_PAIR :
        (func == amd_pkg::FN_WORD_QUAD && minor == amd_pkg::MN_INT_DOT) ? amd_pkg::OP_DOT_QUAD :
        (func == amd_pkg::FN_PAIR && minor == amd_pkg::MN_FRAC_DOT) ? amd_pkg::OP_DOT_FRAC :
        amd_pkg::OP_NONE;
    // operand values never raise an exception; only decode and enable do
    assign known       = (op != amd_pkg::OP_NONE);
    assign enabled     = enable_q[amd_pkg::ENABLE_BIT];
    assign exec        = issue_req.valid & known & enabled;
    assign refuse_resv = issue_req.valid & ~known;
    assign refuse_dis  = issue_req.valid & known & ~enabled;

    // ****************************************************************
    // multiplier lanes
    // ****************************************************************
    logic [1:0][63:0]        pw;
    logic [3:0][31:0]        ph;
    logic                    word_signed;

    assign word_signed = (op == amd_pkg::OP_MSUB);
    // one lane per word and per halfword; halfwords are always signed
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_word
            amd_mult #(.W(32)) u_word (
                .a         (opa[32*g +: 32]),
                .b         (opb[32*g +: 32]),
                .is_signed (word_signed),
                .prod      (pw[g])
            );
        end
        for (g = 0; g < 4; g++) begin : g_half
            amd_mult #(.W(16)) u_half (
                .a         (opa[16*g +: 16]),
                .b         (opb[16*g +: 16]),
                .is_signed (1'b1),
                .prod      (ph[g])
            );
        end
    endgenerate

    // ****************************************************************
    // arithmetic
    // ****************************************************************
    logic [127:0]            cur_acc;
    logic [127:0]            ext_w1;
    logic [127:0]            ext_w0;
    logic [32:0]             dot_pair;
    logic [63:0]             sum_pair;
    logic [33:0]             dot_quad;
    logic [1:0]              frac_sat;
    logic [1:0][31:0]        qprod;
    logic [63:0]             dot_frac;
    logic [63:0]             sum_frac;
    logic [127:0]            next_acc;

    assign cur_acc = acc_q[idx];
    // word products widened to 128 bits by sign or zero
    assign ext_w1 = {{64{word_signed & pw[1][63]}}, pw[1]};
    assign ext_w0 = {{64{word_signed & pw[0][63]}}, pw[0]};
    // pair integer dot product on the low 32 bits of each half
    assign dot_pair = {ph[1][31], ph[1]} + {ph[0][31], ph[0]};
    assign sum_pair = {cur_acc[95:64], cur_acc[31:0]} + {{31{dot_pair[32]}}, dot_pair};
    // quad sum carries two guard bits, enough for four 32-bit products
    assign dot_quad = {{2{ph[3][31]}}, ph[3]} + {{2{ph[2][31]}}, ph[2]}
                    + {{2{ph[1][31]}}, ph[1]} + {{2{ph[0][31]}}, ph[0]};
    // Q15 x Q15: only minus one squared overflows the shifted product
    generate
        for (g = 0; g < 2; g++) begin : g_q15
            assign frac_sat[g] = (opa[16*g +: 16] == amd_pkg::Q15_MINUS_ONE) &&
                                 (opb[16*g +: 16] == amd_pkg::Q15_MINUS_ONE);
            assign qprod[g]    = frac_sat[g] ? amd_pkg::Q31_MAX :
                                               {ph[g][30:0], 1'b0};
        end
    endgenerate
    assign dot_frac = {{32{qprod[1][31]}}, qprod[1]} + {{32{qprod[0][31]}}, qprod[0]};
    assign sum_frac = {cur_acc[95:64], cur_acc[31:0]} + dot_frac;
    // new value of the selected accumulator, by operation
    always_comb begin
        case (op)
            amd_pkg::OP_MSUB, amd_pkg::OP_MSUBU: begin
                next_acc = cur_acc - ext_w1 - ext_w0;
            end
            amd_pkg::OP_SHIFT_IN: begin
                next_acc = {cur_acc[63:0], opa};
            end
            amd_pkg::OP_DOT_PAIR: begin
                next_acc = {{32{sum_pair[63]}}, sum_pair[63:32],
                            {32{sum_pair[31]}}, sum_pair[31:0]};
            end
            amd_pkg::OP_DOT_QUAD: begin
                next_acc = cur_acc + {{94{dot_quad[33]}}, dot_quad};
            end
            amd_pkg::OP_DOT_FRAC: begin
                next_acc = {{32{sum_frac[63]}}, sum_frac[63:32],
                            {32{sum_frac[31]}}, sum_frac[31:0]};
            end
            default: begin
                next_acc = cur_acc;
            end
        endcase
    end

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    logic                    bus_req;
    logic                    bus_wr;
    logic                    hit_ctrl;
    logic                    hit_enable;
    logic                    hit_status;
    logic                    hit_mask;
    logic                    hit_acc;
    logic [1:0]              acc_n;
    logic [1:0]              acc_w;
    logic [31:0]             byte_mask;
    logic [31:0]             rd_word;

    // write commits on the edge at which the master sees ack
    assign bus_req    = wb_cyc_i & wb_stb_i;
    assign bus_wr     = bus_req & wb_we_i & wb_ack_o;
    assign hit_ctrl   = (wb_adr_i == amd_pkg::OFS_CTRL);
    assign hit_enable = (wb_adr_i == amd_pkg::OFS_ENABLE);
    assign hit_status = (wb_adr_i == amd_pkg::OFS_STATUS);
    assign hit_mask   = (wb_adr_i == amd_pkg::OFS_MASK);
    assign hit_acc    = (wb_adr_i >= amd_pkg::OFS_ACC_BASE) && (wb_adr_i < amd_pkg::OFS_ACC_END);
    assign acc_n      = wb_adr_i[5:4];
    assign acc_w      = wb_adr_i[3:2];
    assign byte_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // read mux; unmapped addresses read zero
    assign rd_word = hit_ctrl   ? ctrl_q :
                     hit_enable ? enable_q :
                     hit_status ? {29'h0, status_q} :
                     hit_mask   ? {29'h0, mask_q} :
                     hit_acc    ? acc_q[acc_n][32*acc_w +: 32] :
                     32'h0;
    // ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            wb_dat_o <= rd_word;
        end
    end

    // ****************************************************************
    // next-state of accumulators, control and interrupt registers
    // ****************************************************************
    // instruction beats a same-cycle software write to its accumulator
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            next_acc_arr[n] = acc_q[n];
            if (bus_wr && hit_acc && acc_n == 2'(n)) begin
                next_acc_arr[n][32*acc_w +: 32] =
                    (acc_q[n][32*acc_w +: 32] & ~byte_mask) | (wb_dat_i & byte_mask);
            end
            if (exec && idx == 2'(n)) begin
                next_acc_arr[n] = next_acc;
            end
        end
    end
    // control register: hardware updates win over software
    always_comb begin
        next_ctrl = ctrl_q;
        if (bus_wr && hit_ctrl) begin
            next_ctrl = (ctrl_q & ~byte_mask) | (wb_dat_i & byte_mask);
        end
        if (exec && op == amd_pkg::OP_SHIFT_IN) begin
            // wraps modulo 128 when the old position was 64 or more
            next_ctrl[amd_pkg::POS_LSB +: amd_pkg::POS_W] =
                ctrl_q[amd_pkg::POS_LSB +: amd_pkg::POS_W] + amd_pkg::POS_STEP;
        end
        if (exec && op == amd_pkg::OP_DOT_FRAC && frac_sat != 2'b00) begin
            next_ctrl[amd_pkg::SATFLAG_LSB + idx] = 1'b1;
        end
    end
    // sticky events: set wins over write-one-to-clear
    assign next_status = (status_q & ~((bus_wr && hit_status) ?
                                       wb_dat_i[amd_pkg::EV_W-1:0] : 3'h0))
                       | {refuse_dis, refuse_resv,
                          exec && op == amd_pkg::OP_DOT_FRAC && frac_sat != 2'b00};
    // mask bits all sit in byte lane zero
    assign next_mask   = (bus_wr && hit_mask && wb_sel_i[0]) ?
                         wb_dat_i[amd_pkg::EV_W-1:0] : mask_q;
    // all architectural state commits on one edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_q    <= '0;
            ctrl_q   <= amd_pkg::CTRL_RESET;
            enable_q <= amd_pkg::ENABLE_RESET;
            status_q <= amd_pkg::EV_RESET;
            mask_q   <= amd_pkg::EV_RESET;
            irq      <= 1'b0;
        end else begin
            acc_q    <= next_acc_arr;
            ctrl_q   <= next_ctrl;
            enable_q <= (bus_wr && hit_enable) ?
                        (enable_q & ~byte_mask) | (wb_dat_i & byte_mask) : enable_q;
            status_q <= next_status;
            mask_q   <= next_mask;
            irq      <= |(next_status & next_mask);
        end
    end

    // answer to the pipeline, one cycle after issue
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            issue_rsp <= '0;
        end else begin
            issue_rsp.done               <= exec;
            issue_rsp.exc_reserved       <= refuse_resv;
            issue_rsp.exc_disabled       <= refuse_dis;
            issue_rsp.accumulator_select <= idx;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [127:0]            ref_sub;
    logic [127:0]            ref_quad;

    // reference products built independently of the lanes
    assign ref_sub = word_signed ?
        128'($signed(opa[63:32])) * 128'($signed(opb[63:32])) +
        128'($signed(opa[31:0])) * 128'($signed(opb[31:0])) :
        128'(opa[63:32]) * 128'(opb[63:32]) + 128'(opa[31:0]) * 128'(opb[31:0]);
    assign ref_quad =
        128'($signed(opa[63:48])) * 128'($signed(opb[63:48])) +
        128'($signed(opa[47:32])) * 128'($signed(opb[47:32])) +
        128'($signed(opa[31:16])) * 128'($signed(opb[31:16])) +
        128'($signed(opa[15:0])) * 128'($signed(opb[15:0]));

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_exec_shift;
        exec && op == amd_pkg::OP_SHIFT_IN;
    endsequence
    sequence s_exec_frac_sat;
        exec && op == amd_pkg::OP_DOT_FRAC && frac_sat != 2'b00;
    endsequence

    a_msub_value: assert property (
        exec && (op == amd_pkg::OP_MSUB || op == amd_pkg::OP_MSUBU)
        |=> acc_q[$past(idx)] == $past(cur_acc) - $past(ref_sub))
        else $error("multiply-subtract result wrong");
    a_shift_move: assert property (
        s_exec_shift |=> acc_q[$past(idx)] == {$past(cur_acc[63:0]), $past(opa)})
        else $error("shift-in halves wrong");
    a_pos_advance: assert property (
        s_exec_shift ##0 (ctrl_q[6:0] <= amd_pkg::POS_LIMIT)
        |=> ctrl_q[6:0] == 7'($past(ctrl_q[6:0]) + amd_pkg::POS_STEP))
        else $error("position field not advanced by 64");
    a_quad_value: assert property (
        exec && op == amd_pkg::OP_DOT_QUAD |=> acc_q[$past(idx)] == $past(cur_acc) + $past(ref_quad))
        else $error("quad dot product wrong");
    a_intdot_noflag: assert property (
        exec && (op == amd_pkg::OP_DOT_PAIR || op == amd_pkg::OP_DOT_QUAD) && !(bus_wr && hit_ctrl)
        |=> $stable(ctrl_q[amd_pkg::OUFLAG_LSB +: amd_pkg::OUFLAG_W]))
        else $error("integer dot product touched flags");
    a_sat_flag: assert property (
        s_exec_frac_sat |=> ctrl_q[amd_pkg::SATFLAG_LSB + $past(idx)] && status_q[amd_pkg::EV_SAT])
        else $error("saturation flag not set");
    a_other_kept: assert property (
        exec && !(bus_wr && hit_acc) |=> acc_q[$past(idx) + 2'd1] == $past(acc_q[idx + 2'd1]))
        else $error("unselected accumulator changed");
    a_refused_clean: assert property (
        issue_req.valid && !exec && !bus_wr
        |=> $stable(acc_q) && $stable(ctrl_q) && !issue_rsp.done
            && (issue_rsp.exc_reserved != issue_rsp.exc_disabled))
        else $error("refused instruction changed state");
    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule // amd_unit

`default_nettype wire

// ---- testbench/amd_pipe_model.sv ----
// Purpose: pipeline stand-in issuing one decoded instruction at a time
// Assumes: answer comes one cycle after the taking edge
// Notes:   released operands are inverted so stale values never pass
`timescale 1ns/10ps
`default_nettype none
module amd_pipe_model (
    input  wire logic                 clk,  // core clock
    output var  amd_pkg::amd_issue_t  req,  // instruction to the unit
    input  wire amd_pkg::amd_result_t rsp   // completion or exception
);
    initial req = '0;
    // one-cycle valid pulse; answer read at the edge after the taking edge
    task automatic send(input logic [31:0] i, input logic [63:0] a, b,
        output amd_pkg::amd_result_t r);
        @(posedge clk) req <= {1'b1, i, a, b};
        @(posedge clk) req <= {1'b0, ~i, ~a, ~b};
        @(posedge clk) r = rsp;
    endtask
endmodule // amd_pipe_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for amd_unit
// Assumes: bus and issue answers one cycle after the taking edge
// Notes:   expected values worked out by hand from chosen operands
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, q;
    int err_count = 0, samples_checked = 0;
    amd_pkg::amd_issue_t req;
    amd_pkg::amd_result_t rsp, r;
    always #2.5 clk = ~clk; // 200 MHz
    amd_unit dut_u (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .issue_req(req), .issue_rsp(rsp), .irq(irq));
    amd_pipe_model pm_u (.clk(clk), .req(req), .rsp(rsp));
    task automatic chk(input logic [31:0] g, e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    // classic cycle held until ack; a stuck slave counts as a mismatch
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (n == 40) chk(32'h0, 32'h1);
    endtask
    task automatic rg(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic acc(input logic [1:0] n, w, input logic [31:0] e);
        rg(amd_pkg::OFS_ACC_BASE + {2'h0, n, w, 2'h0}, e);
    endtask
    task automatic iss(input logic [4:0] m, input logic [5:0] f, input logic [1:0] c,
        input logic [63:0] a, b, input logic [4:0] e);
        pm_u.send({amd_pkg::EXTENSION_MAJOR_OPCODE, 13'h0, c, m, f}, a, b, r);
        chk({27'h0, r}, {27'h0, e});
    endtask
    // refused while disabled, unknown op refused, then both subtracts
    task automatic s_arith();
        iss(amd_pkg::MN_MSUB, amd_pkg::FN_WORD_QUAD, 2'h1, 64'h0, 64'h0, 5'h05);
        wb(1'b1, amd_pkg::OFS_ENABLE, 32'h1);
        rg(amd_pkg::OFS_ENABLE, 32'h1);
        rg(8'h20, 32'h0);
        iss(5'h00, 6'h00, 2'h0, 64'h0, 64'h0, 5'h08);
        iss(amd_pkg::MN_MSUB, amd_pkg::FN_WORD_QUAD, 2'h1, 64'h2_ffff_ffff, 64'h3_0000_0002,
            5'h11);
        acc(2'h1, 2'h0, 32'hffff_fffc);
        acc(2'h1, 2'h3, 32'hffff_ffff);
        iss(amd_pkg::MN_MSUBU, amd_pkg::FN_WORD_QUAD, 2'h2, 64'h2_ffff_ffff, 64'h3_0000_0002,
            5'h12);
        acc(2'h2, 2'h1, 32'hffff_fffd);
        acc(2'h0, 2'h0, 32'h0);
    endtask
    // two shift-ins: position 0 to 64, then wraps in its 7-bit field
    task automatic s_shift();
        iss(amd_pkg::MN_SHIFT_IN, amd_pkg::FN_EXTRACT, 2'h3, 64'h1111_2222_3333_4444, 64'h0,
            5'h13);
        rg(amd_pkg::OFS_CTRL, 32'h40);
        iss(amd_pkg::MN_SHIFT_IN, amd_pkg::FN_EXTRACT, 2'h3, 64'h5555_6666_7777_8888, 64'h0,
            5'h13);
        acc(2'h3, 2'h2, 32'h3333_4444);
        acc(2'h3, 2'h1, 32'h5555_6666);
        rg(amd_pkg::OFS_CTRL, 32'h0);
    endtask
    // saturating product raises flag and interrupt; integer dots keep flags
    task automatic s_dot();
        wb(1'b1, amd_pkg::OFS_MASK, 32'h1);
        iss(amd_pkg::MN_FRAC_DOT, amd_pkg::FN_PAIR, 2'h2, 64'h8000_8000, 64'h8000_8000,
            5'h12);
        acc(2'h2, 2'h0, 32'hffff_fffa);
        acc(2'h2, 2'h2, 32'h0);
        rg(amd_pkg::OFS_CTRL, 32'h0004_0000);
        chk({31'h0, irq}, 32'h1);
        rg(amd_pkg::OFS_STATUS, 32'h7);
        wb(1'b1, amd_pkg::OFS_STATUS, 32'h7);
        rg(amd_pkg::OFS_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        iss(amd_pkg::MN_INT_DOT, amd_pkg::FN_PAIR, 2'h1, 64'h3_0002, 64'h4_ffff, 5'h11);
        acc(2'h1, 2'h0, 32'h6);
        acc(2'h1, 2'h2, 32'h0);
        iss(amd_pkg::MN_FRAC_DOT, amd_pkg::FN_PAIR, 2'h1, 64'h2_4000, 64'h3_4000, 5'h11);
        acc(2'h1, 2'h0, 32'h2000_0012);
        iss(amd_pkg::MN_INT_DOT, amd_pkg::FN_WORD_QUAD, 2'h0, 64'hffff_0002_0003_0004,
            64'h0001_0002_0003_0004, 5'h10);
        acc(2'h0, 2'h0, 32'h1c);
        wb(1'b1, amd_pkg::OFS_ACC_BASE, 32'h0);
        acc(2'h0, 2'h0, 32'h0);
        rg(amd_pkg::OFS_CTRL, 32'h0004_0000);
    endtask
    task automatic complete_run();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        s_arith();
        s_shift();
        s_dot();
        complete_run();
    end
    // watchdog far beyond the hundred or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
